// file: src/odp_pkg.sv
// Shared constants for the octal DDR pseudo-static RAM bus port
package odp_pkg;
    localparam int ADDR_W       = 24;
    localparam int LAT_W        = 4;
    localparam int CA_BYTES     = 6;
    localparam logic [7:0] OP_READ   = 8'hee;
    localparam logic [7:0] OP_WRITE  = 8'hde;
    localparam logic [7:0] OP_REG_WR = 8'h71;
    localparam logic [3:0] LAT_DEF   = 4'h6;
    localparam logic [1:0] WRAP_DEF  = 2'h0;
    localparam logic [7:0] BYTE_RST  = 8'h00;
    typedef enum logic [2:0] {
        ODP_IDLE = 3'b000,
        ODP_CMD  = 3'b001,
        ODP_CA   = 3'b011,
        ODP_LAT  = 3'b010,
        ODP_DATA = 3'b110,
        ODP_DONE = 3'b111
    } odp_state_t;
endpackage : odp_pkg

// file: src/odp_mem_if.sv
// Word access channel between the link port and the array
`timescale 1ns/100ps
`default_nettype none
interface odp_mem_if;
    logic [odp_pkg::ADDR_W-1:0] addr;
    logic                       wr_en;
    logic [1:0]                 wr_be;
    logic [15:0]                wr_data;
    logic [15:0]                rd_data;
    modport port (output addr, output wr_en, output wr_be,
                  output wr_data, input rd_data);
    modport array (input addr, input wr_en, input wr_be,
                   input wr_data, output rd_data);
endinterface : odp_mem_if
`default_nettype wire

// file: src/odp_array.sv
// Word array with byte write enables and asynchronous read
`timescale 1ns/100ps
`default_nettype none
module odp_array #(
    parameter int DEPTH_W = 10
) (
    input  wire logic clk,
    odp_mem_if.array  mem
);
    logic [15:0] store [0:(1<<DEPTH_W)-1];

    assign mem.rd_data = store[mem.addr[DEPTH_W-1:0]];

    // Upper byte is the first, lowest-addressed byte on the wire
    always_ff @(posedge clk) begin
        if (mem.wr_en && mem.wr_be[1]) begin
            store[mem.addr[DEPTH_W-1:0]][15:8] <= mem.wr_data[15:8];
        end
        if (mem.wr_en && mem.wr_be[0]) begin
            store[mem.addr[DEPTH_W-1:0]][7:0] <= mem.wr_data[7:0];
        end
    end
endmodule : odp_array
`default_nettype wire

// file: src/odp_port.sv
// Slave side of the octal DDR link: framing, latency, bursts
`timescale 1ns/100ps
`default_nettype none
module odp_port #(
    parameter int         DEPTH_W  = 10,
    parameter logic [3:0] LAT      = odp_pkg::LAT_DEF,
    parameter logic [1:0] WRAP     = odp_pkg::WRAP_DEF,
    parameter bit         WRAPPED  = 1'b0,
    parameter bit         DUAL_DIE = 1'b1
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       cs_n,
    input  wire logic       serial_clk,
    input  wire logic       serial_clk_n,
    input  wire logic       reset_n,
    input  wire logic       refresh_due,
    input  wire logic [7:0] dq_in,
    output logic      [7:0] dq_out,
    output logic            dq_oe,
    input  wire logic       strobe_mask_in,
    output logic            strobe_mask_out,
    output logic            strobe_mask_oe,
    output logic            busy
);
    localparam int AW = odp_pkg::ADDR_W;

    odp_mem_if mem ();
    odp_array #(.DEPTH_W(DEPTH_W)) u_array (.clk(clk), .mem(mem));

    // Two-stage synchronisers for every pin input
    logic [2:0] s1_ctl, s2_ctl;
    logic [7:0] s1_dq, s2_dq;
    logic       s1_rw, s2_rw, s1_ckn, s2_ckn;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s1_ctl <= 3'h5;
            s2_ctl <= 3'h5;
            s1_dq  <= 8'h00;
            s2_dq  <= 8'h00;
            s1_rw  <= 1'b0;
            s2_rw  <= 1'b0;
            s1_ckn <= 1'b1;
            s2_ckn <= 1'b1;
        end else begin
            s1_ctl <= {reset_n, serial_clk, cs_n};
            s2_ctl <= s1_ctl;
            s1_dq  <= dq_in;
            s2_dq  <= s1_dq;
            s1_rw  <= strobe_mask_in;
            s2_rw  <= s1_rw;
            s1_ckn <= serial_clk_n;
            s2_ckn <= s1_ckn;
        end
    end

    logic ck_q, cs_q;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ck_q <= 1'b0;
            cs_q <= 1'b1;
        end else begin
            ck_q <= s2_ctl[1];
            cs_q <= s2_ctl[0];
        end
    end
    // Differential mode only qualifies the rising edge by the complement; the falling edge is not qualified
    logic cs_sel, ck_rise, ck_fall, any_edge, hw_rst;
    assign cs_sel   = !s2_ctl[0];
    assign hw_rst   = !s2_ctl[2];
    assign ck_rise  = s2_ctl[1] && !ck_q && !s2_ckn;
    assign ck_fall  = !s2_ctl[1] && ck_q;
    assign any_edge = cs_sel && (ck_rise || ck_fall);

    odp_pkg::odp_state_t state;
    logic [7:0]    opcode;
    logic [2:0]    ca_cnt;
    logic [AW-1:0] addr;
    logic [6:0]    lat_cnt;
    logic          extra_lat;
    logic          half;
    logic [7:0]    wr_hi;
    logic          wr_hi_mask;
    logic          is_read, is_write;

    assign is_read  = opcode == odp_pkg::OP_READ;
    assign is_write = opcode == odp_pkg::OP_WRITE;

    // Latency in edges: two edges per clock, doubled on refresh or when DUAL_DIE is set
    logic [6:0] lat_edges;
    assign lat_edges = (extra_lat || DUAL_DIE)
                       ? {1'b0, LAT, 2'b00}
                       : {2'b00, LAT, 1'b0};

    function automatic logic [AW-1:0] next_word(input logic [AW-1:0] a);
        logic [AW-1:0] lin;
        logic [AW-1:0] msk;
        lin = a + 1'b1;
        msk = AW'((32'd8 << WRAP) - 32'd1);
        if (WRAPPED) begin
            next_word = (a & ~msk) | (lin & msk);
        end else begin
            // Wraps to zero past the top of the array
            next_word = lin & AW'((32'd1 << DEPTH_W) - 32'd1);
        end
    endfunction : next_word

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state     <= odp_pkg::ODP_IDLE;
            opcode    <= odp_pkg::BYTE_RST;
            ca_cnt    <= 3'h0;
            addr      <= '0;
            lat_cnt   <= 7'h00;
            extra_lat <= 1'b0;
            half      <= 1'b0;
        end else if (hw_rst || !cs_sel) begin
            state <= odp_pkg::ODP_IDLE;
            half  <= 1'b0;
        end else begin
            case (state)
                odp_pkg::ODP_IDLE: begin
                    if (cs_q) begin
                        state     <= odp_pkg::ODP_CMD;
                        extra_lat <= refresh_due;
                    end
                end
                odp_pkg::ODP_CMD: begin
                    if (ck_rise) begin
                        opcode <= s2_dq;
                    end else if (ck_fall) begin
                        // Both edges carry the opcode, second one ignored
                        state  <= odp_pkg::ODP_CA;
                        ca_cnt <= 3'h0;
                    end
                end
                odp_pkg::ODP_CA: begin
                    if (any_edge) begin
                        addr   <= {addr[AW-9:0], s2_dq};
                        ca_cnt <= ca_cnt + 3'h1;
                        if (ca_cnt == 3'(odp_pkg::CA_BYTES - 1)) begin
                            lat_cnt <= lat_edges;
                            state <= (opcode == odp_pkg::OP_REG_WR)
                                     ? odp_pkg::ODP_DONE
                                     : odp_pkg::ODP_LAT;
                        end
                    end
                end
                odp_pkg::ODP_LAT: begin
                    if (any_edge) begin
                        lat_cnt <= lat_cnt - 7'h1;
                        if (lat_cnt == 7'h1) begin
                            state <= (is_read || is_write)
                                     ? odp_pkg::ODP_DATA
                                     : odp_pkg::ODP_DONE;
                            half  <= 1'b0;
                        end
                    end
                end
                odp_pkg::ODP_DATA: begin
                    if (any_edge) begin
                        half <= !half;
                        if (half) begin
                            addr <= next_word(addr);
                        end
                    end
                end
                odp_pkg::ODP_DONE: begin
                    state <= odp_pkg::ODP_DONE;
                end
                default: state <= odp_pkg::ODP_IDLE;
            endcase
        end
    end

    // Write capture: first byte on rise, second on fall
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_hi      <= odp_pkg::BYTE_RST;
            wr_hi_mask <= 1'b1;
        end else if (state == odp_pkg::ODP_DATA && is_write && ck_rise) begin
            wr_hi      <= s2_dq;
            wr_hi_mask <= s2_rw;
        end
    end

    logic wr_fire;
    assign wr_fire = state == odp_pkg::ODP_DATA && is_write && ck_fall
                     && cs_sel && !hw_rst;
    assign mem.addr    = addr;
    assign mem.wr_en   = wr_fire;
    assign mem.wr_be   = {!wr_hi_mask, !s2_rw};
    assign mem.wr_data = {wr_hi, s2_dq};

    // Pin drivers, all registered
    logic rd_phase;
    assign rd_phase = state == odp_pkg::ODP_DATA && is_read;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dq_out          <= 8'h00;
            dq_oe           <= 1'b0;
            strobe_mask_out <= 1'b0;
            strobe_mask_oe  <= 1'b0;
            busy            <= 1'b0;
        end else if (hw_rst || !cs_sel) begin
            dq_oe          <= 1'b0;
            strobe_mask_oe <= 1'b0;
            busy           <= 1'b0;
        end else begin
            busy <= state != odp_pkg::ODP_IDLE;
            if (state == odp_pkg::ODP_CMD || state == odp_pkg::ODP_CA) begin
                strobe_mask_oe  <= 1'b1;
                strobe_mask_out <= extra_lat || DUAL_DIE;
            end else if (rd_phase) begin
                strobe_mask_oe <= 1'b1;
                dq_oe          <= 1'b1;
                if (any_edge) begin
                    // Strobe and byte change together on each edge
                    strobe_mask_out <= !half;
                    dq_out <= half ? mem.rd_data[7:0]
                                   : mem.rd_data[15:8];
                end
            end else begin
                // Host owns the strobe for masking during writes
                strobe_mask_oe  <= 1'b0;
                strobe_mask_out <= 1'b0;
                dq_oe           <= 1'b0;
            end
        end
    end

    // Steps shared by the multi-step checks below
    sequence odp_ca_done;
        cs_sel && !hw_rst && state == odp_pkg::ODP_CA && any_edge
        && ca_cnt == 3'(odp_pkg::CA_BYTES - 1);
    endsequence
    sequence odp_read_edge;
        rd_phase && any_edge && !hw_rst;
    endsequence

    chk_release_cs: assert property (
        @(posedge clk) disable iff (!rstn)
        !cs_sel |=> !dq_oe && !strobe_mask_oe)
        else $error("lines driven while deselected");
    chk_hw_reset: assert property (
        @(posedge clk) disable iff (!rstn)
        hw_rst |=> state == odp_pkg::ODP_IDLE && !dq_oe)
        else $error("reset did not idle the port");
    chk_ca_strobe: assert property (
        @(posedge clk) disable iff (!rstn)
        cs_sel && !hw_rst && state == odp_pkg::ODP_CA
        |=> strobe_mask_oe && strobe_mask_out == (extra_lat || DUAL_DIE))
        else $error("latency flag not driven");
    chk_write_owner: assert property (
        @(posedge clk) disable iff (!rstn)
        state == odp_pkg::ODP_DATA && is_write && cs_sel && !hw_rst
        |=> !strobe_mask_oe)
        else $error("strobe driven during write data");
    chk_regwr_nolat: assert property (
        @(posedge clk) disable iff (!rstn)
        state == odp_pkg::ODP_LAT |-> opcode != odp_pkg::OP_REG_WR)
        else $error("register write entered latency");
    chk_lat_count: assert property (
        @(posedge clk) disable iff (!rstn)
        state == odp_pkg::ODP_CA && $past(state) == odp_pkg::ODP_CA
        && any_edge && ca_cnt == 3'(odp_pkg::CA_BYTES - 1)
        |=> lat_cnt == lat_edges)
        else $error("latency count wrong");
    chk_mask_write: assert property (
        @(posedge clk) disable iff (!rstn)
        mem.wr_en |-> mem.wr_be[0] == !s2_rw)
        else $error("mask not applied");
    chk_read_drive: assert property (
        @(posedge clk) disable iff (!rstn)
        rd_phase && cs_sel && !hw_rst |=> dq_oe && strobe_mask_oe)
        else $error("read data not driven");
    chk_dual_die: assert property (
        @(posedge clk) disable iff (!rstn)
        DUAL_DIE && state == odp_pkg::ODP_LAT |-> lat_edges[6:2] == 5'(LAT))
        else $error("dual die latency not doubled");
    // Register writes go straight from address to the data-less tail
    chk_regwr_skip: assert property (
        @(posedge clk) disable iff (!rstn)
        odp_ca_done ##0 (opcode == odp_pkg::OP_REG_WR)
        |=> state == odp_pkg::ODP_DONE)
        else $error("register write did not skip latency");
    chk_read_toggle: assert property (
        @(posedge clk) disable iff (!rstn)
        odp_read_edge |=> $changed(strobe_mask_out))
        else $error("strobe did not toggle with read data");
endmodule : odp_port
`default_nettype wire

// file: dv/odp_host.sv
// Host controller model for the octal DDR link
`timescale 1ns/100ps
`default_nettype none
module odp_host #(
    parameter int LAT = int'(odp_pkg::LAT_DEF)
) (
    input  wire logic       clk,
    input  wire logic [7:0] dq_wire,
    input  wire logic       mask_wire,
    output logic            cs_n,
    output logic            serial_clk,
    output logic            serial_clk_n,
    output logic      [7:0] dq_drv,
    output logic            dq_en,
    output logic            mask_drv,
    output logic            mask_en
);
    logic [7:0] seen;
    logic       seen_mask;
    logic       lat_two;
    logic       diff_clk;
    initial begin
        diff_clk = 1'b1;
        cs_n = 1'b1; // Private select line
        serial_clk = 1'b0;
        serial_clk_n = 1'b1;
        dq_drv = 8'h00;
        dq_en = 1'b0;
        mask_drv = 1'b0;
        mask_en = 1'b0;
        seen = 8'h00;
        seen_mask = 1'b0;
        lat_two = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Samples the answer to the previous edge, then makes the next edge
    task automatic step(input logic [7:0] d, input logic m,
                        input logic den, input logic men);
        tick(2);
        dq_drv = d;
        dq_en = den;
        mask_drv = m;
        mask_en = men; // Mask only in write data
        tick(2);
        // Port answers three clocks after an edge, so look just before
        seen = dq_wire;
        seen_mask = mask_wire;
        serial_clk = ~serial_clk; // Differential pair
        serial_clk_n = diff_clk ? ~serial_clk : 1'b0;
    endtask : step
    // Single-ended use ties the complement low between frames
    task automatic clk_mode(input logic diff);
        diff_clk = diff;
        serial_clk_n = diff ? ~serial_clk : 1'b0;
    endtask : clk_mode
    task automatic open_frame(input logic [7:0] op, input logic [23:0] a);
        logic [47:0] ca;
        ca = {24'h000000, a};
        cs_n = 1'b0; // Select with the clock idle
        step(op, 1'b0, 1'b1, 1'b0);
        step(op, 1'b0, 1'b1, 1'b0);
        for (int i = 5; i >= 0; i--) begin
            step(ca[i*8 +: 8], 1'b0, 1'b1, 1'b0);
        end
        lat_two = seen_mask; // Latency read off the strobe
    endtask : open_frame
    task automatic latency();
        for (int i = 0; i < (lat_two ? 4 : 2) * LAT; i++) begin
            step(8'h00, 1'b0, 1'b0, 1'b0); // Full count clocked
        end
    endtask : latency
    // Bursts kept a few words long so refresh is never starved
    task automatic close_frame();
        tick(4);
        cs_n = 1'b1; // Clock idle low at the end
        dq_en = 1'b0;
        mask_en = 1'b0;
        tick(6);
    endtask : close_frame
endmodule : odp_host
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the octal DDR link port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        clk, rstn, reset_n, refresh_due, busy;
    logic        cs_n, serial_clk, serial_clk_n;
    logic [7:0]  dq_out, h_dq, dq_wire, dq_last;
    logic        dq_oe, h_dq_en, h_mk, h_mk_en;
    logic        mask_out, mask_oe, mask_wire, mask_last;
    logic [15:0] mem [16];
    int          fails, total_checks;
    // No pulls: a released line shows the inverse of its last level
    assign dq_wire = dq_oe ? dq_out : (h_dq_en ? h_dq : ~dq_last);
    assign mask_wire = mask_oe ? mask_out : (h_mk_en ? h_mk : ~mask_last);
    always @(posedge clk) begin
        if (!rstn) begin
            dq_last   <= 8'h00;
            mask_last <= 1'b0;
        end else begin
            if (dq_oe || h_dq_en) dq_last <= dq_wire;
            if (mask_oe || h_mk_en) mask_last <= mask_wire;
        end
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    odp_port #(.DEPTH_W(4), .DUAL_DIE(1'b0)) dut (
        .clk(clk), .rstn(rstn), .cs_n(cs_n), .serial_clk(serial_clk),
        .serial_clk_n(serial_clk_n), .reset_n(reset_n),
        .refresh_due(refresh_due), .dq_in(dq_wire), .dq_out(dq_out),
        .dq_oe(dq_oe), .strobe_mask_in(mask_wire),
        .strobe_mask_out(mask_out), .strobe_mask_oe(mask_oe), .busy(busy));
    odp_host host (
        .clk(clk), .dq_wire(dq_wire), .mask_wire(mask_wire), .cs_n(cs_n),
        .serial_clk(serial_clk), .serial_clk_n(serial_clk_n),
        .dq_drv(h_dq), .dq_en(h_dq_en), .mask_drv(h_mk), .mask_en(h_mk_en));
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict
    task automatic rd_byte(input logic [23:0] a, input int j,
                           input logic [7:0] d, input logic m);
        logic [15:0] e;
        logic [7:0]  x;
        e = mem[(a[3:0] + j / 2) % 16]; // Linear, rolls over
        x = j[0] ? e[7:0] : e[15:8];
        check("read byte", {8'h00, d}, {8'h00, x});
        check("read strobe", {15'h0, m}, {15'h0, !j[0]});
    endtask : rd_byte
    // Writes update the expected array; reads are compared byte by byte
    task automatic frame(input logic wr, input logic [23:0] a, input int n,
                         input logic [7:0] base, input logic [31:0] msk);
        int w;
        logic [7:0] b;
        host.open_frame(wr ? odp_pkg::OP_WRITE : odp_pkg::OP_READ, a);
        check("ca strobe drive", {15'h0, mask_oe}, 16'h0001);
        check("latency flag", 16'(host.lat_two), 16'(refresh_due));
        check("busy frame", {15'h0, busy}, 16'h0001);
        host.latency();
        for (int k = 0; k < 2 * n; k++) begin
            w = (a[3:0] + k / 2) % 16;
            b = base + 8'(k * 17);
            if (wr && !msk[k] && (k % 2) == 0) mem[w][15:8] = b;
            if (wr && !msk[k] && (k % 2) == 1) mem[w][7:0] = b;
            host.step(b, msk[k], wr, wr);
            if (!wr && k > 0) rd_byte(a, k - 1, host.seen, host.seen_mask);
        end
        if (!wr) begin
            host.tick(4);
            rd_byte(a, 2 * n - 1, dq_wire, mask_wire);
        end
        host.close_frame();
        check("dq release", {15'h0, dq_oe}, 16'h0000);
        check("strobe release", {15'h0, mask_oe}, 16'h0000);
        for (int i = 0; i < 40 && busy !== 1'b0; i++)
            host.tick(1);
        check("busy idle", {15'h0, busy}, 16'h0000);
    endtask : frame
    task automatic s_write_read();
        frame(1'b1, 24'h000000, 4, 8'h10, 32'h0);
        frame(1'b1, 24'h000001, 2, 8'h50, 32'h6); // Middle bytes masked
        frame(1'b0, 24'h000000, 4, 8'h00, 32'h0);
    endtask : s_write_read
    task automatic s_latency();
        refresh_due = 1'b1;
        frame(1'b0, 24'h000000, 4, 8'h00, 32'h0);
        frame(1'b1, 24'h000002, 1, 8'h70, 32'h1);
        refresh_due = 1'b0;
        frame(1'b0, 24'h000002, 1, 8'h00, 32'h0);
    endtask : s_latency
    task automatic s_rollover();
        frame(1'b1, 24'h00000f, 1, 8'h90, 32'h0);
        frame(1'b0, 24'h00000f, 3, 8'h00, 32'h0);
    endtask : s_rollover
    // Register write: no latency, and its data never reaches the array
    task automatic s_reg_write();
        host.open_frame(odp_pkg::OP_REG_WR, 24'h000000);
        host.step(8'h3c, 1'b0, 1'b1, 1'b0);
        host.step(8'hc3, 1'b0, 1'b1, 1'b0);
        host.tick(4);
        check("regwr strobe", {15'h0, mask_oe}, 16'h0000);
        check("regwr busy", {15'h0, busy}, 16'h0001);
        host.close_frame();
        frame(1'b0, 24'h000000, 1, 8'h00, 32'h0);
    endtask : s_reg_write
    task automatic s_single_ended();
        host.clk_mode(1'b0);
        frame(1'b1, 24'h000004, 2, 8'h33, 32'h0);
        frame(1'b0, 24'h000004, 2, 8'h00, 32'h0);
        host.clk_mode(1'b1);
    endtask : s_single_ended
    task automatic s_reset();
        host.open_frame(odp_pkg::OP_READ, 24'h000000);
        host.latency();
        host.step(8'h00, 1'b0, 1'b0, 1'b0);
        host.step(8'h00, 1'b0, 1'b0, 1'b0);
        reset_n = 1'b0;
        host.tick(6);
        check("reset dq", {15'h0, dq_oe}, 16'h0000);
        check("reset strobe", {15'h0, mask_oe}, 16'h0000);
        check("reset busy", {15'h0, busy}, 16'h0000);
        host.close_frame();
        reset_n = 1'b1;
        host.tick(4);
        frame(1'b0, 24'h00000f, 1, 8'h00, 32'h0);
    endtask : s_reset
    initial begin
        rstn = 1'b0;
        reset_n = 1'b1;
        refresh_due = 1'b0;
        fails = 0;
        total_checks = 0;
        host.tick(2);
        rstn = 1'b1;
        host.tick(4);
        s_write_read();
        s_latency();
        s_rollover();
        s_reg_write();
        s_single_ended();
        s_reset();
        give_verdict();
    end
    // Hang guard well past the longest expected run
    initial begin
        #3000000;
        fails++;
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
